// ---- skpc_pkg.sv ----
// Package of constants and types for the conditional-skip execution unit
// Function
// [RQ1] Increment-memory-skip adds one to the addressed byte and writes it back there.
// [RQ2] A met skip inserts a dummy cycle; the skipping execution takes three cycles.
// [RQ3] Accumulator variant loads byte plus one into accumulator, memory unchanged, skips on zero.
// [RQ4] Bit-test skips the following instruction when the selected memory bit is set.
// [RQ5] Bit-test does not skip when the selected bit is zero.
// [RQ6] Both increment instructions do not skip when the incremented result is nonzero.
// [RQ7] Increment wraps all ones to zero, skipping; no status flag is altered.
package skpc_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 9;
  localparam int unsigned BITSEL_W    = 3;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [1:0]  CYC_NORMAL  = 2'h2;
  localparam logic [1:0]  CYC_SKIP    = 2'h3;

  typedef enum logic [1:0] {
    SKPC_OP_NONE     = 2'b00,
    SKPC_OP_INC_MEM  = 2'b01,
    SKPC_OP_INC_ACC  = 2'b10,
    SKPC_OP_BIT_TEST = 2'b11
  } skpc_op_t;

  typedef enum logic [1:0] {
    SKPC_IDLE  = 2'b00,
    SKPC_READ  = 2'b01,
    SKPC_EXEC  = 2'b10,
    SKPC_DUMMY = 2'b11
  } skpc_state_t;
endpackage : skpc_pkg

// ---- skpc_incr.sv ----
`timescale 1ns/100ps
// Wrapping incrementer with zero detect
module skpc_incr #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] value_i,
  output logic      [W-1:0] sum_o,
  output logic              zero_o
);
  // Carry out is dropped on purpose so all ones wraps to zero
  assign sum_o  = value_i + {{(W-1){1'b0}}, 1'b1}; // see [RQ7]
  assign zero_o = (sum_o == '0);
endmodule // skpc_incr

// ---- skpc_unit.sv ----
`timescale 1ns/100ps
// Execution unit for increment-skip and bit-test-skip instructions
module skpc_unit
  import skpc_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  // Clock and reset
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  // Instruction issue
  input  wire logic            start_i,
  input  wire logic [1:0]      op_i,
  input  wire logic [AW-1:0]   addr_i,
  input  wire logic [2:0]      bit_sel_i,
  // Data memory
  input  wire logic [7:0]      mem_rdata_i,
  output logic                 mem_rd_o,
  output logic                 mem_wr_o,
  output logic      [AW-1:0]   mem_addr_o,
  output logic      [7:0]      mem_wdata_o,
  // Core side results
  output logic      [7:0]      accumulator_o,
  output logic                 busy_o,
  output logic                 skip_o,
  output logic                 dummy_o,
  output logic                 done_o
);
  skpc_state_t     state;
  skpc_state_t     next_state;
  skpc_op_t        op;
  skpc_op_t        next_op;
  logic [2:0]      bit_sel;
  logic [2:0]      next_bit_sel;
  logic            mem_rd;
  logic            next_mem_rd;
  logic            mem_wr;
  logic            next_mem_wr;
  logic [AW-1:0]   mem_addr;
  logic [AW-1:0]   next_mem_addr;
  logic [7:0]      mem_wdata;
  logic [7:0]      next_mem_wdata;
  logic [7:0]      accumulator;
  logic [7:0]      next_accumulator;
  logic            skip;
  logic            next_skip;
  logic            dummy;
  logic            next_dummy;
  logic            done;
  logic            next_done;
  logic [7:0]      sum;
  logic            sum_zero;
  logic            cond;

  skpc_incr #(
    .W (DATA_W)
  ) u_incr (
    .value_i (mem_rdata_i),
    .sum_o   (sum),
    .zero_o  (sum_zero)
  );

  // Skip condition per instruction
  always_comb begin
    unique case (op)
      SKPC_OP_INC_MEM:  cond = sum_zero;                // see [RQ6]
      SKPC_OP_INC_ACC:  cond = sum_zero;                // see [RQ3] see [RQ6]
      SKPC_OP_BIT_TEST: cond = mem_rdata_i[bit_sel];    // see [RQ4] see [RQ5]
      SKPC_OP_NONE:     cond = 1'b0;
    endcase
  end

  // Issue and phase decodes shared by all state groups
  logic            take;
  logic            exec;
  logic            busy;
  logic            next_busy;

  // A request is taken only while idle; an all-zero opcode is dropped silently
  assign take = (state == SKPC_IDLE) && start_i && (skpc_op_t'(op_i) != SKPC_OP_NONE);
  assign exec = (state == SKPC_EXEC);

  // Sequencing group: phase, latched opcode, latched bit index and busy
  always_comb begin
    next_state   = state;
    next_op      = op;
    next_bit_sel = bit_sel;
    unique case (state)
      SKPC_IDLE: begin
        if (take) begin
          next_op      = skpc_op_t'(op_i);
          next_bit_sel = bit_sel_i;
          next_state   = SKPC_READ;
        end
      end
      SKPC_READ: begin
        // Read data is valid one cycle after the strobe
        next_state = SKPC_EXEC;
      end
      SKPC_EXEC: begin
        if (cond) begin
          next_state = SKPC_DUMMY;                      // see [RQ2]
        end else begin
          next_state = SKPC_IDLE;                       // see [RQ5] see [RQ6]
        end
      end
      SKPC_DUMMY: begin
        // Dummy slot replaces the skipped instruction: third cycle
        next_state = SKPC_IDLE;                         // see [RQ2]
      end
    endcase
    // Busy looks one state ahead so that it is a flop yet tracks the phase exactly
    next_busy = (next_state != SKPC_IDLE);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state   <= SKPC_IDLE;
      op      <= SKPC_OP_NONE;
      bit_sel <= 3'h0;
      busy    <= 1'b0;
    end else begin
      state   <= next_state;
      op      <= next_op;
      bit_sel <= next_bit_sel;
      busy    <= next_busy;
    end
  end

  // Address group: held from issue so a write lands where the read came from
  always_comb begin
    next_mem_addr = mem_addr;
    if (take) begin
      next_mem_addr = addr_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr <= '0;
    end else begin
      mem_addr <= next_mem_addr;
    end
  end

  // Memory strobe group: only the in-place increment writes the byte back
  always_comb begin
    next_mem_rd    = take;
    next_mem_wr    = 1'b0;
    next_mem_wdata = mem_wdata;
    if (exec && (op == SKPC_OP_INC_MEM)) begin
      next_mem_wr    = 1'b1;                            // see [RQ1]
      next_mem_wdata = sum;                             // see [RQ1]
    end
    // Accumulator variant and bit test never raise the write strobe, see [RQ3]
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_rd    <= next_mem_rd;
      mem_wr    <= next_mem_wr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Accumulator group
  always_comb begin
    next_accumulator = accumulator;
    if (exec && (op == SKPC_OP_INC_ACC)) begin
      next_accumulator = sum;                           // see [RQ3]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      accumulator <= ACC_RESET;
    end else begin
      accumulator <= next_accumulator;
    end
  end

  // Result strobe group: skip, dummy and done each stand for one cycle
  always_comb begin
    next_skip  = 1'b0;
    next_dummy = 1'b0;
    next_done  = 1'b0;
    if (exec) begin
      // No flag outputs exist, so status flags stay untouched
      if (cond) begin
        next_skip  = 1'b1;
        next_dummy = 1'b1;                              // see [RQ2]
      end else begin
        next_done  = 1'b1;
      end
    end
    if (state == SKPC_DUMMY) begin
      next_done = 1'b1;                                 // see [RQ2]
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      skip  <= 1'b0;
      dummy <= 1'b0;
      done  <= 1'b0;
    end else begin
      skip  <= next_skip;
      dummy <= next_dummy;
      done  <= next_done;
    end
  end

  assign mem_rd_o      = mem_rd;
  assign mem_wr_o      = mem_wr;
  assign mem_addr_o    = mem_addr;
  assign mem_wdata_o   = mem_wdata;
  assign accumulator_o = accumulator;
  assign busy_o        = busy;
  assign skip_o        = skip;
  assign dummy_o       = dummy;
  assign done_o        = done;
endmodule // skpc_unit

// ---- skpc_mem_model.sv ----
`timescale 1ns/100ps
// Data memory model facing the skip unit
module skpc_mem_model (
  input  wire logic       clock_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [8:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o = 8'h00
);
  logic [7:0] mem [512];
  logic [1:0] hold = 2'h0;
  // Data stands three cycles, then toggles so a late sample is caught
  always @(posedge clock_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    if (rd_i) {rdata_o, hold} <= {mem[addr_i], 2'h2};
    else if (hold != 2'h0) hold <= hold - 2'h1;
    else rdata_o <= ~rdata_o;
  end
endmodule // skpc_mem_model

// ---- skpc_unit_asserts.sv ----
`timescale 1ns/100ps
// Port checker of the skip unit
module skpc_unit_chk
  import skpc_pkg::*;
#(parameter int unsigned AW = ADDR_W) (
  input wire logic       clock_i, rst_i, start_i, busy_o, mem_rd_o, mem_wr_o, skip_o, dummy_o, done_o,
  input wire logic [1:0] op_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] mem_rdata_i, mem_wdata_o, accumulator_o
);
  logic [1:0] op_q;
  logic [2:0] sel_q;
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i) {op_q, sel_q} <= '0;
    else if (start_i && !busy_o) {op_q, sel_q} <= {op_i, bit_sel_i};
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_wr_incr: assert property (
    mem_wr_o |-> mem_wdata_o == 8'($past(mem_rdata_i) + 1)) else $error("bad write data");
  a_skip_seq: assert property (
    skip_o |-> dummy_o && !done_o ##1 done_o && !skip_o) else $error("bad skip sequence");
  a_three_cyc: assert property (
    done_o && $past(skip_o) |-> $past(mem_rd_o, 3)) else $error("skip not three cycles");
  a_inc_skip: assert property (
    op_q != 2'h3 && $past(mem_rd_o, 2) |-> skip_o == (8'($past(mem_rdata_i) + 1) == 8'h00))
    else $error("bad increment skip");
  a_acc_load: assert property (
    op_q == 2'h2 && $past(mem_rd_o, 2) |-> !mem_wr_o && accumulator_o == 8'($past(mem_rdata_i) + 1))
    else $error("bad accumulator");
  a_bit_skip: assert property (
    op_q == 2'h3 && $past(mem_rd_o, 2) |-> skip_o == $past(mem_rdata_i[sel_q])) else $error("bad bit skip");
  a_bit_noskip: assert property (
    op_q == 2'h3 && $past(mem_rd_o, 2) && !skip_o |-> done_o && !mem_wr_o) else $error("bad bit pass");
  c_skip: cover property (skip_o);
  c_wrap: cover property (mem_wr_o && mem_wdata_o == 8'h00);
  c_plain: cover property (done_o && !$past(skip_o));
endmodule // skpc_unit_chk
bind skpc_unit skpc_unit_chk #(.AW(AW)) u_chk (.clock_i, .rst_i, .start_i, .busy_o, .mem_rd_o, .mem_wr_o,
  .skip_o, .dummy_o, .done_o, .op_i, .bit_sel_i, .mem_rdata_i, .mem_wdata_o, .accumulator_o);

// ---- tb_top.sv ----
`timescale 1ns/100ps
// Self-checking bench of the skip unit
module tb_top;
  import skpc_pkg::*;
  logic       clock_i = 0, rst_i = 1, start_i = 0;
  logic [1:0] op_i = 0;
  logic [2:0] bit_sel_i = 0;
  logic [8:0] addr_i = 0, mem_addr_o;
  logic [7:0] mem_rdata_i, mem_wdata_o, accumulator_o, acc_exp;
  logic       mem_rd_o, mem_wr_o, busy_o, skip_o, dummy_o, done_o;
  int         err_total = 0, tests_run = 0, seed = 42, cyc = 0;
  skpc_unit u_skpc_unit (.clock_i, .rst_i, .start_i, .op_i, .addr_i, .bit_sel_i, .mem_rdata_i, .mem_rd_o,
    .mem_wr_o, .mem_addr_o, .mem_wdata_o, .accumulator_o, .busy_o, .skip_o, .dummy_o, .done_o);
  skpc_mem_model u_skpc_mem_model (.clock_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  initial forever #25 clock_i = ~clock_i;
  always @(posedge clock_i) if (++cyc > 5000) begin
    err_total++;
    print_verdict;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  function automatic logic want_skip(logic [1:0] op, logic [7:0] v, logic [2:0] b);
    return op == 2'h3 ? v[b] : 8'(v + 1) == 8'h00;
  endfunction
  // Entered at a falling edge with the unit idle
  task automatic run(logic [1:0] op, logic [8:0] a, logic [2:0] b, logic [7:0] v);
    int n;
    logic sk;
    n = 1;
    sk = 0;
    u_skpc_mem_model.mem[a] = v;
    {op_i, addr_i, bit_sel_i, start_i} = {op, a, b, 1'b1};
    @(negedge clock_i) start_i = 0;
    while (done_o !== 1'b1 && n < 10) begin
      @(negedge clock_i);
      n++;
      sk |= skip_o;
    end
    if (op == 2'h2) acc_exp = 8'(v + 1);
    chk("skip", 8'(want_skip(op, v, b)), 8'(sk));
    chk("cycles", want_skip(op, v, b) ? 8'(CYC_SKIP) + 8'h01 : 8'(CYC_NORMAL) + 8'h01, 8'(n));
    chk("accumulator", acc_exp, accumulator_o);
    @(negedge clock_i);
    chk("memory", op == 2'h1 ? 8'(v + 1) : v, u_skpc_mem_model.mem[a]);
    $display("test op %0d value %h ended", op, v);
  endtask
  initial begin
    acc_exp = ACC_RESET;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i) rst_i = 0;
    chk("reset accumulator", ACC_RESET, accumulator_o);
    // Wrap and zero corners first, then random bytes
    for (int i = 0; i < 60; i++)
      run(2'(i % 3 + 1), 9'($random(seed)), 3'(i), i < 3 ? 8'hFF : i < 6 ? 8'h00 : 8'($random(seed)));
    {op_i, start_i} = {2'h0, 1'b1};
    @(negedge clock_i) start_i = 0;
    @(negedge clock_i);
    chk("ignored op busy", 8'h00, 8'(busy_o));
    print_verdict;
  end
endmodule // tb_top
